//--- design/sbs_pkg.sv
// ****************************************************************
// Shared constants and types
// ****************************************************************
package sbs_pkg;
	localparam int ADDR_W = 20;
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int BEAT_W = 2;
	localparam int FIRST_BEAT_CYCLES = 2;
	localparam int NEXT_BEAT_CYCLES = 1;
	localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;
	localparam logic [LANES-1:0] LANES_NONE = 4'h0;
	localparam logic [LANES-1:0] LANES_ALL = 4'hf;
	localparam logic MODE_LINEAR = 1'b0;
	localparam logic MODE_INTERLEAVED = 1'b1;

	typedef enum logic [2:0] {
		ACC_IDLE = 3'b001,
		ACC_READ = 3'b010,
		ACC_WRITE = 3'b100
	} sbs_acc_e;

	// Lane enables from the write controls, all lanes on a global write
	function automatic logic [LANES-1:0] sbs_lane_we(
		input logic gw_n,
		input logic bwe_n,
		input logic [LANES-1:0] bw_n
	);
		if (!gw_n) begin
			return LANES_ALL;
		end else if (!bwe_n) begin
			return ~bw_n;
		end
		return LANES_NONE;
	endfunction : sbs_lane_we
endpackage : sbs_pkg

//--- design/sbs_ctr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Link between the access logic and the burst counter
// ****************************************************************
interface sbs_ctr_if;
	import sbs_pkg::*;
	logic load;
	logic step;
	logic mode;
	logic [BEAT_W-1:0] start;
	logic [BEAT_W-1:0] low;
	modport ctl (output load, output step, output mode, output start,
		input low);
	modport ctr (input load, input step, input mode, input start,
		output low);
endinterface : sbs_ctr_if
`default_nettype wire

//--- design/sbs_burst_ctr.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Two-bit burst counter
// ****************************************************************
module sbs_burst_ctr
	import sbs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	sbs_ctr_if.ctr ctr
);
	typedef struct packed {
		logic [BEAT_W-1:0] start;
		logic [BEAT_W-1:0] beat;
		logic [BEAT_W-1:0] low;
		logic mode;
	} sbs_ctr_s;

	sbs_ctr_s st_q;
	sbs_ctr_s st_d;

	// Load takes the start value, step moves one beat and wraps at four
	always_comb begin
		st_d = st_q;
		if (ctr.load) begin
			st_d.start = ctr.start;
			st_d.beat = BEAT_RST;
			st_d.mode = ctr.mode;
		end else if (ctr.step) begin
			st_d.beat = st_q.beat + 2'h1;
		end
		// Order chosen by the mode level kept with the burst
		if (st_d.mode == MODE_INTERLEAVED) begin
			st_d.low = st_d.start ^ st_d.beat;
		end else begin
			st_d.low = st_d.start + st_d.beat;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ctr.low = st_q.low;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_interleave_order: assert property (
		st_q.mode |-> st_q.low == (st_q.start ^ st_q.beat))
		else $error("interleaved address not start xor beat");
	a_linear_order: assert property (
		!ctr.load && ctr.step && !st_q.mode
			|=> st_q.low == $past(st_q.low) + 2'h1)
		else $error("linear address did not count up");
	a_step_hold: assert property (
		!ctr.load && !ctr.step |=> $stable(st_q.low))
		else $error("burst address moved without advance");
	c_wrap: cover property (ctr.step && st_q.beat == 2'h3);
endmodule : sbs_burst_ctr
`default_nettype wire

//--- design/sync_burst_sram_interface.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Mode high interleaved, low linear order
// - Counter loads first address, makes the rest
// - Capture address only when a strobe active
// - Advance input alone steps the burst
// - All synchronous inputs registered on rising edge
// - Output enable and sleep act without clock
// - Burst timing two, one, one, one clocks
// - Processor strobe ignored while chip select high
// - Global write low writes every byte
// - Byte writes need gate and lane select
// - Counter steps when advance sampled low
module sync_burst_sram_interface
	import sbs_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic processor_addr_strobe_n,
	input wire logic controller_addr_strobe_n,
	input wire logic burst_advance_n,
	input wire logic primary_chip_select_n,
	input wire logic depth_chip_select_high,
	input wire logic depth_chip_select_low_n,
	input wire logic [LANES-1:0] byte_lane_write_select_n,
	input wire logic byte_write_gate_n,
	input wire logic global_write_all_n,
	input wire logic burst_mode,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	output logic [ADDR_W-1:0] mem_addr,
	output logic [DATA_W-1:0] mem_wdata,
	output logic [LANES-1:0] mem_lane_we,
	output logic mem_read,
	output logic dq_oe,
	output logic sleep_active
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic ap_n;
		logic ac_n;
		logic adv_n;
		logic ce1_n;
		logic ce2;
		logic ce3_n;
		logic [LANES-1:0] bw_n;
		logic bwe_n;
		logic gw_n;
		logic mode;
	} sbs_in_s;

	typedef struct packed {
		sbs_in_s pin;
		logic sel;
		logic [ADDR_W-1:BEAT_W] base;
		sbs_acc_e acc;
		logic [DATA_W-1:0] wdata;
		logic [LANES-1:0] we;
	} sbs_state_s;

	sbs_state_s st_q;
	sbs_state_s st_d;

	sbs_ctr_if ctr_if ();

	logic ads_p_go;
	logic ads_c_go;
	logic load;
	logic chip_hit;
	logic [LANES-1:0] wr_lanes;

	// ****************************************************************
	// Decode of the registered pins
	// ****************************************************************
	// Strobes are judged on the registered copies so every decision but the sleep gate
	// sits one full cycle behind the pins, giving the fixed first beat
	always_comb begin
		ads_p_go = !st_q.pin.ap_n && !st_q.pin.ce1_n;
		ads_c_go = !st_q.pin.ac_n;
		load = (ads_p_go || ads_c_go) && !sleep_request;
		chip_hit = !st_q.pin.ce1_n && st_q.pin.ce2 && !st_q.pin.ce3_n;
		wr_lanes = sbs_lane_we(st_q.pin.gw_n, st_q.pin.bwe_n,
			st_q.pin.bw_n);
	end

	// Counter control: load on a strobe, step only on advance
	always_comb begin
		ctr_if.load = load && chip_hit;
		ctr_if.step = !load && st_q.sel && !st_q.pin.adv_n;
		ctr_if.start = st_q.pin.addr[BEAT_W-1:0];
		ctr_if.mode = st_q.pin.mode;
	end

	sbs_burst_ctr u_ctr (
		.clk_sys(clk_sys),
		.reset(reset),
		.ctr(ctr_if.ctr)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		st_d = st_q;
		// Every synchronous pin goes through the input register
		st_d.pin.addr = addr;
		st_d.pin.wdata = wdata;
		st_d.pin.ap_n = processor_addr_strobe_n;
		st_d.pin.ac_n = controller_addr_strobe_n;
		st_d.pin.adv_n = burst_advance_n;
		st_d.pin.ce1_n = primary_chip_select_n;
		st_d.pin.ce2 = depth_chip_select_high;
		st_d.pin.ce3_n = depth_chip_select_low_n;
		st_d.pin.bw_n = byte_lane_write_select_n;
		st_d.pin.bwe_n = byte_write_gate_n;
		st_d.pin.gw_n = global_write_all_n;
		st_d.pin.mode = burst_mode;
		st_d.wdata = st_q.pin.wdata;
		st_d.acc = ACC_IDLE;
		if (sleep_request) begin
			// Sleep drops the selection, a new strobe is needed after
			st_d.sel = 1'b0;
		end else if (load) begin
			st_d.sel = chip_hit;
			if (chip_hit) begin
				st_d.base = st_q.pin.addr[ADDR_W-1:BEAT_W];
				// Processor-strobe cycles always read; writes follow later
				if (ads_p_go || wr_lanes == LANES_NONE) begin
					st_d.acc = ACC_READ;
				end else begin
					st_d.acc = ACC_WRITE;
				end
			end
		end else if (st_q.sel) begin
			if (wr_lanes != LANES_NONE) begin
				st_d.acc = ACC_WRITE;
			end else if (!st_q.pin.adv_n) begin
				st_d.acc = ACC_READ;
			end
		end
		if (st_d.acc == ACC_WRITE) begin
			st_d.we = wr_lanes;
		end else begin
			st_d.we = LANES_NONE;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			st_q <= '0;
			st_q.acc <= ACC_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign mem_addr = {st_q.base, ctr_if.low};
	assign mem_wdata = st_q.wdata;
	assign mem_lane_we = st_q.we;
	assign mem_read = (st_q.acc == ACC_READ);
	// Drive enable and sleep bypass the clock by intent
	assign dq_oe = !output_enable_n && mem_read && !sleep_request;
	assign sleep_active = sleep_request;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_proc_start;
		!processor_addr_strobe_n && !primary_chip_select_n &&
			depth_chip_select_high && !depth_chip_select_low_n &&
			!sleep_request ##1 !sleep_request;
	endsequence

	a_first_beat: assert property (
		s_proc_start |=> mem_read)
		else $error("first beat not two clocks after strobe");
	a_next_beat: assert property (
		st_q.sel && !load && !sleep_request && !st_q.pin.adv_n &&
			wr_lanes == LANES_NONE |=> mem_read)
		else $error("following beat not one clock later");
	a_load_capture: assert property (
		load && chip_hit
			|=> st_q.base == $past(st_q.pin.addr[ADDR_W-1:BEAT_W]))
		else $error("address not captured on strobe");
	a_no_strobe_hold: assert property (
		!load |=> $stable(st_q.base))
		else $error("address changed without a strobe");
	// A processor strobe with the primary select high, with no advance or write, gives no capture and no beat
	a_ce1_blocks: assert property (
		!st_q.pin.ap_n && st_q.pin.ce1_n && st_q.pin.ac_n &&
			st_q.pin.adv_n && wr_lanes == LANES_NONE
			|=> $stable(st_q.base) && !mem_read && mem_lane_we == 4'h0)
		else $error("processor strobe taken while deselected");
	a_global_write: assert property (
		st_q.sel && !load && !sleep_request && !st_q.pin.gw_n
			|=> mem_lane_we == 4'hf)
		else $error("global write did not write all lanes");
	a_lane_write: assert property (
		st_q.sel && !load && !sleep_request && st_q.pin.gw_n
			|=> mem_lane_we == ($past(st_q.pin.bwe_n) ? 4'h0
				: ~$past(st_q.pin.bw_n)))
		else $error("byte lanes not gated by byte write gate");
	a_adv_step: assert property (
		st_q.sel && !load && !st_q.pin.adv_n && !st_q.pin.mode
			|=> mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1)
		else $error("advance low did not step the counter");
	a_async_oe: assert property (
		output_enable_n || sleep_request |-> !dq_oe)
		else $error("output driven while disabled");

	c_proc_burst: cover property (s_proc_start ##1 !burst_advance_n [*3]);
	c_ctrl_write: cover property (load && ads_c_go && !ads_p_go &&
		wr_lanes != LANES_NONE);
	c_interleave: cover property (ctr_if.step && st_q.pin.mode);
endmodule : sync_burst_sram_interface
`default_nettype wire

//--- dv/sbs_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********
// Host side: processor or cache controller on the pins
// ********
module sbs_host_model
	import sbs_pkg::*;
#(
	parameter logic [ADDR_W-3:0] ADDR_HI = 18'h2a5c3
)
(
	output var logic [ADDR_W-1:0] addr,
	output var logic [DATA_W-1:0] wdata,
	output var logic processor_addr_strobe_n,
	output var logic controller_addr_strobe_n,
	output var logic burst_advance_n,
	output var logic primary_chip_select_n,
	output var logic depth_chip_select_high,
	output var logic depth_chip_select_low_n,
	output var logic global_write_all_n,
	output var logic byte_write_gate_n,
	output var logic burst_mode,
	output var logic [LANES-1:0] byte_lane_write_select_n
);
	// One bus cycle: strobes, selects, controls, lane selects, low bits
	task automatic drive(input logic [15:0] c);
		{processor_addr_strobe_n, controller_addr_strobe_n} = c[15:14];
		{burst_advance_n, primary_chip_select_n} = c[13:12];
		{depth_chip_select_high, global_write_all_n} = c[11:10];
		{byte_write_gate_n, burst_mode} = c[9:8];
		byte_lane_write_select_n = c[7:4];
		depth_chip_select_low_n = c[2];
		// With no strobe the address is junk, so a stray capture shows
		if (c[15] && c[14])
			addr = ~addr;
		else
			addr = {ADDR_HI, c[1:0]};
		wdata = {addr[17:0], ~addr[17:0]};
	endtask : drive

	// Idle bus from time zero
	initial begin
		addr = '0;
		drive(16'heef0);
	end
endmodule : sbs_host_model
`default_nettype wire

//--- dv/test_sync_burst_sram_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_sync_burst_sram_interface
	import sbs_pkg::*;
;
	localparam logic [ADDR_W-3:0] HI = 18'h2a5c3;
	logic clk_sys, reset, output_enable_n, sleep_request;
	logic [ADDR_W-1:0] addr, mem_addr;
	logic [DATA_W-1:0] wdata, mem_wdata;
	logic processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n;
	logic primary_chip_select_n, depth_chip_select_high, global_write_all_n;
	logic byte_write_gate_n, burst_mode, mem_read, dq_oe, sleep_active;
	logic depth_chip_select_low_n;
	logic [LANES-1:0] byte_lane_write_select_n, mem_lane_we;
	int miscompares = 0;
	int comparisons = 0;
	int cycles = 0;
	logic [7:0] ex;
	logic [DATA_W-1:0] hist [37];
	// Row: pin code (16 bits), then we, read, low bits seen two cycles on
	// A write with advance low lands on the next burst address
	// Last rows: third select off deselects, so advance reads nothing
	logic [23:0] rows [37] = '{
		24'h6ef100, 24'hcef000, 24'hcef009, 24'hcef00a, 24'heef00b,
		24'heef008, 24'haff100, 24'hcff000, 24'hcff009, 24'hcff008,
		24'heff00b, 24'heff00a, 24'h7ef000, 24'heef000, 24'heaf000,
		24'heef000, 24'hec50f2, 24'hee0000, 24'heef0a2, 24'heef000,
		24'haaf300, 24'hcaf000, 24'heef0f3, 24'heef0f0, 24'h66f000,
		24'hcef000, 24'hcaf000, 24'heef000, 24'heef000, 24'h6ef000,
		24'h4ef200, 24'heef008, 24'heef00a, 24'h6ef400, 24'hcef000,
		24'heef000, 24'heef000};

	// Free-running 100 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	sbs_host_model #(.ADDR_HI(HI)) host_u (.addr, .wdata,
		.processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .primary_chip_select_n, .depth_chip_select_high,
		.depth_chip_select_low_n, .global_write_all_n, .byte_write_gate_n,
		.burst_mode, .byte_lane_write_select_n);

	sync_burst_sram_interface dut_u (.clk_sys, .reset, .addr, .wdata,
		.processor_addr_strobe_n, .controller_addr_strobe_n,
		.burst_advance_n, .primary_chip_select_n, .depth_chip_select_high,
		.depth_chip_select_low_n, .byte_lane_write_select_n,
		.byte_write_gate_n, .global_write_all_n, .burst_mode,
		.output_enable_n, .sleep_request, .mem_addr, .mem_wdata,
		.mem_lane_we, .mem_read, .dq_oe, .sleep_active);

	// ********
	// Checking and closing
	// ********
	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic results();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results

	// A hang costs a mismatch; the whole run needs well under 100 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 1000) begin
			miscompares++;
			results();
		end
	end

	// ********
	// Main sequence
	// ********
	initial begin
		reset = 1'b1;
		output_enable_n = 1'b1;
		sleep_request = 1'b0;
		repeat (10) @(negedge clk_sys);
		check("reset outputs", DATA_W'({mem_read, mem_lane_we, mem_addr}), '0);
		$display("test reset done");
		reset = 1'b0;
		// One idle edge first: cleared pin registers read as strobes
		@(negedge clk_sys);
		for (int i = 0; i < 37; i++) begin
			ex = rows[i][7:0];
			check("mem_read", DATA_W'(mem_read), DATA_W'(ex[3]));
			check("mem_lane_we", DATA_W'(mem_lane_we), DATA_W'(ex[7:4]));
			if (ex[3] || ex[7:4] != 4'h0)
				check("mem_addr", DATA_W'(mem_addr), DATA_W'({HI, ex[1:0]}));
			if (ex[7:4] != 4'h0)
				check("mem_wdata", mem_wdata, hist[i-2]);
			host_u.drive(rows[i][23:8]);
			hist[i] = wdata;
			@(negedge clk_sys);
		end
		$display("test burst rows done");
		// Drive enable and sleep act inside one read beat, no clock
		host_u.drive(16'h6ef1);
		@(negedge clk_sys);
		host_u.drive(16'heef0);
		@(negedge clk_sys);
		output_enable_n = 1'b0;
		#1;
		check("dq_oe on", DATA_W'(dq_oe), DATA_W'(1'b1));
		output_enable_n = 1'b1;
		#1;
		check("dq_oe off", DATA_W'(dq_oe), '0);
		output_enable_n = 1'b0;
		sleep_request = 1'b1;
		#1;
		check("sleep", DATA_W'({sleep_active, dq_oe}), DATA_W'(2'h2));
		sleep_request = 1'b0;
		reset = 1'b1;
		#1;
		check("reset mid run", DATA_W'({mem_read, mem_lane_we, mem_addr}), '0);
		$display("test async controls done");
		results();
	end
endmodule : test_sync_burst_sram_interface
`default_nettype wire
